// *** abfs_top.v ***
// boost control, battery-guard limiter and fault supervisor of the amplifier
`timescale 1ns/1ps
`include "abfs_regs.vh"

module abfs_top #(
  parameter RETRY_CYCLES = `ABFS_OT_RETRY_CYC,
  parameter MUTE_CYCLES = 256,
  parameter LIM_TICK = 64,
  parameter [7:0] LOOK_MARGIN = 8'h10,
  parameter [7:0] BOOST_HEADROOM = 8'h08
) (
  input wire clk, // 125 MHz clock
  input wire rst_n, // synchronous reset
  input wire [7:0] reg_addr, // register address
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  input wire [7:0] reg_wdata, // write data
  output reg [7:0] reg_rdata_q, // read data
  input wire [7:0] demand_level, // predicted speaker output level
  input wire [7:0] vbat_level, // battery level code
  input wire cmp_overcurrent, // output over-current comparator
  input wire cmp_vdd_uv, // analog supply under 1.5 V
  input wire cmp_vbat_uv, // battery under 2.4 V
  input wire cmp_overtemp, // die over-temperature
  input wire cmp_brownout, // battery under brownout level
  input wire cmp_clk_a_err, // serial audio port clock error
  input wire cmp_clk_b_err, // modulator or PLL clock error
  input wire cmp_vbat_low, // battery under 2.9 V
  output reg boost_en_q, // boost converter enabled
  output reg boost_bypass_q, // battery routed straight to stage
  output reg boost_class_h_q, // level tracking active
  output reg [7:0] boost_level_q, // boost target level
  output reg [1:0] boost_current_ceiling_q, // current-limit code
  output reg [7:0] gain_reduction_q, // limiter attenuation
  output reg audio_channel_en_q, // audio channel enabled
  output reg class_d_power_q, // output stage powered
  output reg dsp_power_q, // DSP core powered
  output reg analog_power_q, // clock dividers and analog powered
  output reg soft_mute_q, // soft-mute ramp requested
  output reg irq_q // interrupt, active high
);

  // ************************************************************
  // input synchronizers
  // ************************************************************
  reg [7:0] sync1_q;
  reg [7:0] sync2_q;
  wire [7:0] raw_in;
  assign raw_in = {cmp_vbat_low, cmp_clk_b_err, cmp_clk_a_err, cmp_brownout,
                   cmp_overtemp, cmp_vbat_uv, cmp_vdd_uv, cmp_overcurrent};

  always @(posedge clk) begin
    if (!rst_n) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  reg [7:0] speaker_boost_control_q;
  reg [7:0] edge_cfg_q;
  reg [7:0] prot_cfg_q;
  reg [1:0] dev_pwr_q;
  reg pwr_fault_q;
  reg [7:0] sticky_q;
  reg [7:0] int_en_q;
  reg [7:0] lim_cmax_q;
  reg [7:0] lim_infl_q;
  reg [7:0] lim_slope_q;
  reg [7:0] lim_rate_q;
  reg [7:0] lim_hyst_q;
  reg [7:0] sticky_set;
  reg [7:0] rdata_d;
  localparam [7:0] PWR_RST = `ABFS_RST_PWR_CTRL2;

  wire wr_pwr;
  wire rd_sticky;
  wire pwr_up_wr;
  wire retry_dis;
  assign wr_pwr = reg_wr && (reg_addr == `ABFS_OFF_PWR_CTRL2);
  assign rd_sticky = reg_rd && (reg_addr == `ABFS_OFF_STICKY);
  assign pwr_up_wr = wr_pwr &&
    (reg_wdata[`ABFS_DEVPWR_HI:`ABFS_DEVPWR_LO] == `ABFS_DEVPWR_ACTIVE);
  assign retry_dis = prot_cfg_q[`ABFS_BIT_OT_RETRY_DIS];

  always @(posedge clk) begin
    if (!rst_n) begin
      speaker_boost_control_q <= `ABFS_RST_SPK_BOOST;
      edge_cfg_q <= `ABFS_RST_EDGE_BOOST;
      prot_cfg_q <= `ABFS_RST_PROT_CFG1;
      dev_pwr_q <= PWR_RST[`ABFS_DEVPWR_HI:`ABFS_DEVPWR_LO];
      int_en_q <= `ABFS_RST_INT_EN;
      lim_cmax_q <= `ABFS_RST_LIM_CMAX;
      lim_infl_q <= `ABFS_RST_LIM_INFL;
      lim_slope_q <= `ABFS_RST_LIM_SLOPE;
      lim_rate_q <= `ABFS_RST_LIM_RATE;
      lim_hyst_q <= `ABFS_RST_LIM_HYST;
    end else if (reg_wr) begin
      case (reg_addr)
        `ABFS_OFF_SPK_BOOST: speaker_boost_control_q <= reg_wdata;
        `ABFS_OFF_EDGE_BOOST: edge_cfg_q <= reg_wdata;
        `ABFS_OFF_PROT_CFG1: prot_cfg_q <= reg_wdata;
        `ABFS_OFF_PWR_CTRL2: dev_pwr_q <= reg_wdata[`ABFS_DEVPWR_HI:`ABFS_DEVPWR_LO];
        `ABFS_OFF_INT_EN: int_en_q <= reg_wdata;
        `ABFS_OFF_LIM_CMAX: lim_cmax_q <= reg_wdata;
        `ABFS_OFF_LIM_INFL: lim_infl_q <= reg_wdata;
        `ABFS_OFF_LIM_SLOPE: lim_slope_q <= reg_wdata;
        `ABFS_OFF_LIM_RATE: lim_rate_q <= reg_wdata;
        `ABFS_OFF_LIM_HYST: lim_hyst_q <= reg_wdata;
        default: speaker_boost_control_q <= speaker_boost_control_q;
      endcase
    end
  end

  always @* begin
    case (reg_addr)
      `ABFS_OFF_SPK_BOOST: rdata_d = speaker_boost_control_q;
      `ABFS_OFF_EDGE_BOOST: rdata_d = edge_cfg_q;
      `ABFS_OFF_PROT_CFG1: rdata_d = prot_cfg_q;
      `ABFS_OFF_PWR_CTRL2: rdata_d = {5'h00, dev_pwr_q, pwr_fault_q};
      `ABFS_OFF_STICKY: rdata_d = sticky_q;
      `ABFS_OFF_INT_EN: rdata_d = int_en_q;
      `ABFS_OFF_LIM_CMAX: rdata_d = lim_cmax_q;
      `ABFS_OFF_LIM_INFL: rdata_d = lim_infl_q;
      `ABFS_OFF_LIM_SLOPE: rdata_d = lim_slope_q;
      `ABFS_OFF_LIM_RATE: rdata_d = lim_rate_q;
      `ABFS_OFF_LIM_HYST: rdata_d = lim_hyst_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_d;
    end
  end

  // ************************************************************
  // fault events
  // ************************************************************
  wire ev_oc;
  wire ev_uv;
  wire ev_ot;
  wire ev_br;
  wire ev_clka;
  wire ev_clkb;
  wire ev_mute;
  assign ev_oc = sync2_q[0] && class_d_power_q;
  assign ev_uv = sync2_q[1] || sync2_q[2];
  assign ev_ot = sync2_q[3] && class_d_power_q;
  assign ev_br = sync2_q[4];
  assign ev_clka = sync2_q[5] && prot_cfg_q[`ABFS_BIT_CLKA_EN];
  assign ev_clkb = sync2_q[6] && prot_cfg_q[`ABFS_BIT_CLKB_EN];
  assign ev_mute = ev_clka || ev_clkb || ev_br;

  always @* begin
    sticky_set = 8'h00;
    sticky_set[`ABFS_STK_OC] = ev_oc;
    sticky_set[`ABFS_STK_UV] = ev_uv;
    sticky_set[`ABFS_STK_CLKA] = ev_clka;
    sticky_set[`ABFS_STK_OT] = ev_ot;
    sticky_set[`ABFS_STK_BRNO] = ev_br;
    sticky_set[`ABFS_STK_CLKB] = ev_clkb;
  end

  // a read clears the flags, but an event in the same cycle survives it
  always @(posedge clk) begin
    if (!rst_n) begin
      sticky_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      sticky_q <= (sticky_q & ~(rd_sticky ? 8'hff : 8'h00)) | sticky_set;
      irq_q <= |(sticky_q & int_en_q);
    end
  end

  // ************************************************************
  // shutdown and recovery
  // ************************************************************
  reg hw_sd_q;
  reg ot_sd_q;
  reg [31:0] retry_cnt_q;
  reg mute_act_q;
  reg mute_done_q;
  reg [15:0] mute_cnt_q;
  reg cause_dsp_q;
  reg cause_an_q;
  wire retry_fire;
  wire mute_release;
  assign retry_fire = ot_sd_q && !retry_dis && (retry_cnt_q == RETRY_CYCLES - 1);
  // release needs flags read and the fault bit cleared, in either order
  assign mute_release = mute_done_q && !ev_mute && !pwr_fault_q &&
    !sticky_q[`ABFS_STK_CLKA] && !sticky_q[`ABFS_STK_CLKB] &&
    !sticky_q[`ABFS_STK_BRNO];

  always @(posedge clk) begin
    if (!rst_n) begin
      hw_sd_q <= 1'b0;
      ot_sd_q <= 1'b0;
      retry_cnt_q <= 32'h0;
      pwr_fault_q <= 1'b0;
    end else begin
      if (ev_oc || ev_uv) begin
        hw_sd_q <= 1'b1;
      end else if (pwr_up_wr) begin
        hw_sd_q <= 1'b0;
      end
      if (ev_ot) begin
        ot_sd_q <= 1'b1;
      end else if (pwr_up_wr || retry_fire) begin
        ot_sd_q <= 1'b0;
      end
      if (ot_sd_q && !retry_dis && !retry_fire) begin
        retry_cnt_q <= retry_cnt_q + 32'h1;
      end else begin
        retry_cnt_q <= 32'h0;
      end
      if (ev_mute) begin
        pwr_fault_q <= 1'b1;
      end else if (wr_pwr && !reg_wdata[`ABFS_BIT_PWR_FAULT]) begin
        pwr_fault_q <= 1'b0;
      end
    end
  end

  // soft mute first, power down only after the ramp has had time
  always @(posedge clk) begin
    if (!rst_n) begin
      mute_act_q <= 1'b0;
      mute_done_q <= 1'b0;
      mute_cnt_q <= 16'h0;
      cause_dsp_q <= 1'b0;
      cause_an_q <= 1'b0;
    end else begin
      if (ev_mute) begin
        mute_act_q <= 1'b1;
        cause_dsp_q <= cause_dsp_q || ev_clka || ev_br;
        cause_an_q <= cause_an_q || ev_br;
      end else if (mute_release) begin
        mute_act_q <= 1'b0;
        cause_dsp_q <= 1'b0;
        cause_an_q <= 1'b0;
      end
      if (mute_release) begin
        mute_done_q <= 1'b0;
        mute_cnt_q <= 16'h0;
      end else if (mute_act_q && !mute_done_q) begin
        if (mute_cnt_q == MUTE_CYCLES - 1) begin
          mute_done_q <= 1'b1;
        end else begin
          mute_cnt_q <= mute_cnt_q + 16'h1;
        end
      end
    end
  end

  wire dev_active;
  assign dev_active = (dev_pwr_q == `ABFS_DEVPWR_ACTIVE) ||
    (dev_pwr_q == `ABFS_DEVPWR_MUTE);

  always @(posedge clk) begin
    if (!rst_n) begin
      audio_channel_en_q <= 1'b0;
      class_d_power_q <= 1'b0;
      dsp_power_q <= 1'b0;
      analog_power_q <= 1'b0;
      soft_mute_q <= 1'b0;
    end else begin
      audio_channel_en_q <= dev_active && !hw_sd_q && !ot_sd_q && !mute_act_q && !ev_mute &&
        !ev_oc && !ev_uv && !ev_ot;
      class_d_power_q <= dev_active && !hw_sd_q && !ot_sd_q && !mute_done_q &&
        !ev_oc && !ev_uv && !ev_ot;
      dsp_power_q <= dev_active && !(mute_done_q && cause_dsp_q);
      analog_power_q <= !(mute_done_q && cause_an_q);
      soft_mute_q <= mute_act_q || ev_mute || (dev_pwr_q == `ABFS_DEVPWR_MUTE);
    end
  end

  // ************************************************************
  // boost control
  // ************************************************************
  wire [8:0] need_sum;
  wire [8:0] track_sum;
  wire boost_need;
  wire class_h;
  assign need_sum = {1'b0, demand_level} + {1'b0, LOOK_MARGIN};
  assign track_sum = {1'b0, demand_level} + {1'b0, BOOST_HEADROOM};
  assign boost_need = need_sum >= {1'b0, vbat_level};
  assign class_h = !speaker_boost_control_q[`ABFS_BIT_BOOST_MODE];

  always @(posedge clk) begin
    if (!rst_n) begin
      boost_en_q <= 1'b0;
      boost_bypass_q <= 1'b1;
      boost_class_h_q <= 1'b0;
      boost_level_q <= 8'h00;
      boost_current_ceiling_q <= 2'h3;
    end else begin
      boost_en_q <= boost_need || sync2_q[7];
      boost_bypass_q <= !(boost_need || sync2_q[7]);
      boost_class_h_q <= class_h;
      if (!(boost_need || sync2_q[7])) begin
        boost_level_q <= vbat_level;
      end else if (class_h) begin
        boost_level_q <= track_sum[8] ? 8'hff : track_sum[7:0];
      end else begin
        boost_level_q <= 8'hff;
      end
      boost_current_ceiling_q <= edge_cfg_q[1:0];
    end
  end

  // ************************************************************
  // battery-guard limiter
  // ************************************************************
  reg [7:0] ceiling;
  reg [15:0] drop;
  reg [15:0] tick_q;
  wire [7:0] lim_out;
  wire [8:0] atk_sum;
  wire [8:0] out_hyst;
  wire [3:0] atk_step;
  wire [3:0] dec_step;
  assign atk_step = lim_rate_q[7:4];
  assign dec_step = lim_rate_q[3:0];
  assign lim_out = (demand_level > gain_reduction_q) ? demand_level - gain_reduction_q : 8'h00;
  assign atk_sum = {1'b0, gain_reduction_q} + {5'h00, atk_step};
  assign out_hyst = {1'b0, lim_out} + {1'b0, lim_hyst_q};

  always @* begin
    drop = 16'h0;
    ceiling = lim_cmax_q;
    if (vbat_level < lim_infl_q) begin
      drop = lim_slope_q * (lim_infl_q - vbat_level);
      ceiling = (drop >= {8'h00, lim_cmax_q}) ? 8'h00 : lim_cmax_q - drop[7:0];
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      tick_q <= 16'h0;
      gain_reduction_q <= 8'h00;
    end else begin
      if (tick_q == LIM_TICK - 1) begin
        tick_q <= 16'h0;
        if (lim_out > ceiling) begin
          gain_reduction_q <= atk_sum[8] ? 8'hff : atk_sum[7:0];
        end else if (out_hyst < {1'b0, ceiling}) begin
          gain_reduction_q <= (gain_reduction_q > {4'h0, dec_step}) ?
            gain_reduction_q - {4'h0, dec_step} : 8'h00;
        end
      end else begin
        tick_q <= tick_q + 16'h1;
      end
    end
  end

endmodule // abfs_top

// *** abfs_regs.vh ***
// register offsets, field positions, reset values and timing counts of the supervisor
`ifndef ABFS_REGS_VH
`define ABFS_REGS_VH

// ************************************************************
// register offsets
// ************************************************************
`define ABFS_OFF_SPK_BOOST 8'h04
`define ABFS_OFF_EDGE_BOOST 8'h05
`define ABFS_OFF_PROT_CFG1 8'h06
`define ABFS_OFF_PWR_CTRL2 8'h07
`define ABFS_OFF_STICKY 8'h08
`define ABFS_OFF_INT_EN 8'h09
`define ABFS_OFF_LIM_CMAX 8'h0a
`define ABFS_OFF_LIM_INFL 8'h0b
`define ABFS_OFF_LIM_SLOPE 8'h0c
`define ABFS_OFF_LIM_RATE 8'h0d
`define ABFS_OFF_LIM_HYST 8'h0e

// ************************************************************
// reset values
// ************************************************************
`define ABFS_RST_SPK_BOOST 8'h10
`define ABFS_RST_EDGE_BOOST 8'h83
`define ABFS_RST_PROT_CFG1 8'h03
`define ABFS_RST_PWR_CTRL2 8'h04
`define ABFS_RST_INT_EN 8'h00
`define ABFS_RST_LIM_CMAX 8'hc0
`define ABFS_RST_LIM_INFL 8'h80
`define ABFS_RST_LIM_SLOPE 8'h02
`define ABFS_RST_LIM_RATE 8'h21
`define ABFS_RST_LIM_HYST 8'h08

// ************************************************************
// field positions
// ************************************************************
`define ABFS_BIT_BOOST_MODE 4
`define ABFS_BIT_CLKA_EN 0
`define ABFS_BIT_CLKB_EN 1
`define ABFS_BIT_OT_RETRY_DIS 2
`define ABFS_BIT_PWR_FAULT 0
`define ABFS_DEVPWR_HI 2
`define ABFS_DEVPWR_LO 1
`define ABFS_DEVPWR_ACTIVE 2'h0
`define ABFS_DEVPWR_MUTE 2'h1
`define ABFS_STK_OC 7
`define ABFS_STK_UV 6
`define ABFS_STK_CLKA 5
`define ABFS_STK_OT 4
`define ABFS_STK_BRNO 3
`define ABFS_STK_CLKB 2

// ************************************************************
// timing
// ************************************************************
`define ABFS_CLK_MHZ 125
`define ABFS_OT_RETRY_MS 100
`define ABFS_OT_RETRY_CYC (`ABFS_OT_RETRY_MS * `ABFS_CLK_MHZ * 1000)

`endif

// *** abfs_checker.sv ***
// assertion checker on the supervisor top-level ports
`timescale 1ns/1ps
`include "abfs_regs.vh"
module abfs_checker #(
  parameter MUTE_CYCLES = 256
) (
  input wire clk, // clock
  input wire rst_n, // reset
  input wire [7:0] reg_addr, // address
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  input wire [7:0] demand_level, // output demand
  input wire [7:0] vbat_level, // battery level
  input wire cmp_overcurrent, // over-current
  input wire cmp_vdd_uv, // supply low
  input wire cmp_vbat_uv, // battery low
  input wire cmp_brownout, // brownout
  input wire cmp_vbat_low, // boost floor
  input wire boost_en_q, // boost on
  input wire boost_bypass_q, // bypass
  input wire [1:0] boost_current_ceiling_q, // limit code
  input wire audio_channel_en_q, // channel on
  input wire class_d_power_q, // stage on
  input wire dsp_power_q, // dsp on
  input wire analog_power_q, // analog on
  input wire soft_mute_q, // mute ramp
  input wire irq_q // interrupt
);
  localparam int MUTE_MAX = MUTE_CYCLES + 8;
  wire wr_limit = reg_wr && reg_addr == `ABFS_OFF_EDGE_BOOST;
  wire ack_rd = reg_rd && reg_addr == `ABFS_OFF_STICKY;
  wire irq_ack = ack_rd || (reg_wr && reg_addr == `ABFS_OFF_INT_EN);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****
  // event sequences, long enough to cross the two-flop synchronizer
  // ****
  sequence s_brownout_held;
    cmp_brownout [*3];
  endsequence
  sequence s_oc_while_on;
    class_d_power_q && cmp_overcurrent ##1 cmp_overcurrent [*2];
  endsequence
  a_bypass_mirrors_boost: assert property (boost_bypass_q == !boost_en_q)
    else $error("bypass and boost enable disagree");
  a_boost_ahead_need: assert property (
    $past(rst_n) && {1'b0, demand_level} + 9'h010 >= {1'b0, vbat_level} |=> boost_en_q)
    else $error("boost not enabled ahead of demand");
  a_low_battery_boost: assert property (cmp_vbat_low [*4] |=> boost_en_q)
    else $error("low battery did not force boost");
  a_limit_on_write: assert property (
    $changed(boost_current_ceiling_q) |-> $past(wr_limit) || $past(wr_limit, 2))
    else $error("current limit changed without a write");
  a_oc_shutdown: assert property (
    s_oc_while_on |=> !class_d_power_q && !audio_channel_en_q)
    else $error("over-current did not shut the stage");
  a_uv_shutdown: assert property (
    (cmp_vdd_uv || cmp_vbat_uv) [*3] |=> !class_d_power_q && !audio_channel_en_q)
    else $error("under-voltage did not shut the stage");
  a_brownout_mute: assert property (
    s_brownout_held |=> ##[0:1] soft_mute_q && !audio_channel_en_q)
    else $error("brownout did not mute");
  a_brownout_power: assert property (
    s_brownout_held |-> ##[1:MUTE_MAX] !class_d_power_q && !dsp_power_q && !analog_power_q)
    else $error("brownout did not power down");
  a_irq_host_clear: assert property (
    $fell(irq_q) |-> $past(irq_ack) || $past(irq_ack, 2))
    else $error("interrupt dropped without host access");
endmodule // abfs_checker

bind abfs_top abfs_checker #(.MUTE_CYCLES(MUTE_CYCLES)) abfs_checker_i (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .demand_level(demand_level), .vbat_level(vbat_level), .cmp_overcurrent(cmp_overcurrent),
  .cmp_vdd_uv(cmp_vdd_uv), .cmp_vbat_uv(cmp_vbat_uv), .cmp_brownout(cmp_brownout),
  .cmp_vbat_low(cmp_vbat_low), .boost_en_q(boost_en_q), .boost_bypass_q(boost_bypass_q),
  .boost_current_ceiling_q(boost_current_ceiling_q), .audio_channel_en_q(audio_channel_en_q),
  .class_d_power_q(class_d_power_q), .dsp_power_q(dsp_power_q),
  .analog_power_q(analog_power_q), .soft_mute_q(soft_mute_q), .irq_q(irq_q));

// *** abfs_host.sv ***
// host model driving the register port and the fault recovery sequences
`timescale 1ns/1ps
`include "abfs_regs.vh"
module abfs_host (
  input wire clk, // clock
  input wire [7:0] reg_rdata_q, // read data
  output reg [7:0] reg_addr, // address
  output reg reg_wr, // write strobe
  output reg reg_rd, // read strobe
  output reg [7:0] reg_wdata // write data
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // ****
  // bus cycles: set on a falling edge, held across one rising edge
  // ****
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(negedge clk);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      // idle lines flip so a stale address never passes for a live one
      reg_addr = ~a;
      reg_wdata = ~v;
    end
  endtask
  task rd(input [7:0] a, output [7:0] v);
    begin
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      @(negedge clk);
      v = reg_rdata_q;
    end
  endtask
  task repower;
    wr(`ABFS_OFF_PWR_CTRL2, 8'h00);
  endtask
  task restart(output [7:0] v);
    begin
      rd(`ABFS_OFF_STICKY, v);
      wr(`ABFS_OFF_PWR_CTRL2, 8'h00);
    end
  endtask
endmodule // abfs_host

// *** abfs_top_bench.sv ***
// self-checking bench for the supervisor with host model and checker
`timescale 1ns/1ps
`include "abfs_regs.vh"
module abfs_top_bench;
  localparam MUTE = 8;
  localparam [7:0] STK = `ABFS_OFF_STICKY;
  localparam [7:0] PWR = `ABFS_OFF_PWR_CTRL2;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] demand_level = 8'h00;
  reg [7:0] vbat_level = 8'h80;
  reg cmp_overcurrent = 1'b0, cmp_vdd_uv = 1'b0, cmp_vbat_uv = 1'b0, cmp_overtemp = 1'b0;
  reg cmp_brownout = 1'b0, cmp_clk_a_err = 1'b0, cmp_clk_b_err = 1'b0, cmp_vbat_low = 1'b0;
  wire [7:0] reg_addr, reg_wdata, reg_rdata_q, boost_level_q, gain_reduction_q;
  wire reg_wr, reg_rd, boost_en_q, boost_bypass_q, boost_class_h_q, audio_channel_en_q;
  wire class_d_power_q, dsp_power_q, analog_power_q, soft_mute_q, irq_q;
  wire [1:0] boost_current_ceiling_q;
  integer mismatches = 0, compares = 0, cycles = 0, i;
  reg [7:0] d;
  abfs_host abfs_host_i (.clk(clk), .reg_rdata_q(reg_rdata_q), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  abfs_top #(.RETRY_CYCLES(50), .MUTE_CYCLES(MUTE), .LIM_TICK(4)) abfs_top_i (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .demand_level(demand_level),
    .vbat_level(vbat_level), .cmp_overcurrent(cmp_overcurrent), .cmp_vdd_uv(cmp_vdd_uv),
    .cmp_vbat_uv(cmp_vbat_uv), .cmp_overtemp(cmp_overtemp), .cmp_brownout(cmp_brownout),
    .cmp_clk_a_err(cmp_clk_a_err), .cmp_clk_b_err(cmp_clk_b_err),
    .cmp_vbat_low(cmp_vbat_low), .boost_en_q(boost_en_q), .boost_bypass_q(boost_bypass_q),
    .boost_class_h_q(boost_class_h_q), .boost_level_q(boost_level_q),
    .boost_current_ceiling_q(boost_current_ceiling_q), .gain_reduction_q(gain_reduction_q),
    .audio_channel_en_q(audio_channel_en_q), .class_d_power_q(class_d_power_q),
    .dsp_power_q(dsp_power_q), .analog_power_q(analog_power_q), .soft_mute_q(soft_mute_q),
    .irq_q(irq_q));
  initial begin
    forever #4 clk = ~clk;
  end
  // ****
  // helpers
  // ****
  task chk(input [7:0] seen, input [7:0] want);
    begin
      compares = compares + 1;
      if (seen !== want) begin
        mismatches = mismatches + 1;
        $display("Error at %0t: saw %h, expected %h", $time, seen, want);
      end
    end
  endtask
  task chk1(input seen, input want);
    chk({7'h00, seen}, {7'h00, want});
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task wr(input [7:0] a, input [7:0] v);
    abfs_host_i.wr(a, v);
  endtask
  task rdchk(input [7:0] a, input [7:0] e);
    begin
      abfs_host_i.rd(a, d);
      chk(d, e);
    end
  endtask
  task wait_on(input integer lim);
    integer n;
    begin
      n = 0;
      while (class_d_power_q !== 1'b1 && n < lim) begin
        @(negedge clk);
        n = n + 1;
      end
    end
  endtask
  task results;
    begin
      $display("mismatches %0d, compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // ****
  // scenarios
  // ****
  task t_reset;
    begin
      rdchk(`ABFS_OFF_SPK_BOOST, `ABFS_RST_SPK_BOOST);
      rdchk(`ABFS_OFF_EDGE_BOOST, `ABFS_RST_EDGE_BOOST);
      rdchk(`ABFS_OFF_PROT_CFG1, `ABFS_RST_PROT_CFG1);
      rdchk(PWR, `ABFS_RST_PWR_CTRL2);
      rdchk(`ABFS_OFF_INT_EN, `ABFS_RST_INT_EN);
      wr(STK, 8'hff);
      rdchk(STK, 8'h00);
      rdchk(8'h30, 8'h00);
      chk1(boost_class_h_q, 1'b0);
      chk1(irq_q, 1'b0);
      for (i = 0; i < 4; i = i + 1) begin
        wr(`ABFS_OFF_EDGE_BOOST, 8'h80 | i[7:0]);
        cyc(2);
        chk({6'h00, boost_current_ceiling_q}, i[7:0]);
      end
    end
  endtask
  task t_boost;
    begin
      demand_level = 8'h50;
      vbat_level = 8'h40;
      cyc(3);
      chk1(boost_en_q, 1'b1);
      chk(boost_level_q, 8'hff);
      wr(`ABFS_OFF_SPK_BOOST, 8'h00);
      cyc(3);
      chk1(boost_class_h_q, 1'b1);
      chk(boost_level_q, 8'h58);
      demand_level = 8'h00;
      vbat_level = 8'h80;
      cyc(3);
      chk1(boost_bypass_q, 1'b1);
      chk(boost_level_q, 8'h80);
      wr(`ABFS_OFF_SPK_BOOST, `ABFS_RST_SPK_BOOST);
      cmp_vbat_low = 1'b1;
      cyc(6);
      chk1(boost_en_q, 1'b1);
      cmp_vbat_low = 1'b0;
    end
  endtask
  task t_limit;
    begin
      cyc(40);
      chk(gain_reduction_q, 8'h00);
      demand_level = 8'hff;
      vbat_level = 8'hff;
      cyc(200);
      chk(gain_reduction_q, 8'h40);
      vbat_level = 8'h70;
      cyc(100);
      chk(gain_reduction_q, 8'h60);
      demand_level = 8'h80;
      cyc(450);
      chk(gain_reduction_q, 8'h00);
      demand_level = 8'h00;
      vbat_level = 8'h80;
    end
  endtask
  task t_oc;
    begin
      cmp_overcurrent = 1'b1;
      cyc(6);
      cmp_overcurrent = 1'b0;
      rdchk(STK, 8'h00);
      wr(`ABFS_OFF_INT_EN, 8'h80);
      abfs_host_i.repower;
      cyc(4);
      chk1(class_d_power_q, 1'b1);
      chk1(audio_channel_en_q, 1'b1);
      cmp_overcurrent = 1'b1;
      cyc(5);
      cmp_overcurrent = 1'b0;
      chk1(audio_channel_en_q, 1'b0);
      chk1(irq_q, 1'b1);
      rdchk(STK, 8'h80);
      cyc(3);
      chk1(irq_q, 1'b0);
      rdchk(STK, 8'h00);
    end
  endtask
  task t_uv;
    for (i = 0; i < 2; i = i + 1) begin
      abfs_host_i.repower;
      cyc(4);
      cmp_vdd_uv = (i == 0);
      cmp_vbat_uv = (i == 1);
      cyc(5);
      cmp_vdd_uv = 1'b0;
      cmp_vbat_uv = 1'b0;
      chk1(class_d_power_q, 1'b0);
      chk1(irq_q, 1'b0);
      cyc(3);
      rdchk(STK, 8'h40);
    end
  endtask
  task t_ot;
    begin
      abfs_host_i.repower;
      cyc(4);
      cmp_overtemp = 1'b1;
      cyc(46);
      chk1(class_d_power_q, 1'b0);
      wait_on(20);
      chk1(class_d_power_q, 1'b1);
      cyc(6);
      chk1(class_d_power_q, 1'b0);
      cmp_overtemp = 1'b0;
      wait_on(80);
      cyc(10);
      chk1(class_d_power_q, 1'b1);
      wr(`ABFS_OFF_PROT_CFG1, 8'h07);
      cmp_overtemp = 1'b1;
      cyc(6);
      cmp_overtemp = 1'b0;
      cyc(80);
      chk1(class_d_power_q, 1'b0);
      rdchk(STK, 8'h10);
      wr(`ABFS_OFF_PROT_CFG1, `ABFS_RST_PROT_CFG1);
    end
  endtask
  task t_brownout;
    begin
      wr(`ABFS_OFF_INT_EN, 8'h08);
      abfs_host_i.repower;
      cyc(4);
      cmp_brownout = 1'b1;
      cyc(5);
      cmp_brownout = 1'b0;
      chk1(soft_mute_q, 1'b1);
      chk1(irq_q, 1'b1);
      cyc(MUTE + 4);
      chk({5'h00, class_d_power_q, dsp_power_q, analog_power_q}, 8'h00);
      rdchk(PWR, 8'h01);
      abfs_host_i.restart(d);
      chk(d, 8'h08);
      cyc(4);
      rdchk(PWR, 8'h00);
      chk1(analog_power_q, 1'b1);
    end
  endtask
  task t_clock;
    for (i = 0; i < 2; i = i + 1) begin
      abfs_host_i.repower;
      cyc(4);
      cmp_clk_a_err = (i == 0);
      cmp_clk_b_err = (i == 1);
      cyc(5);
      cmp_clk_a_err = 1'b0;
      cmp_clk_b_err = 1'b0;
      chk1(soft_mute_q, 1'b1);
      cyc(MUTE + 4);
      chk1(class_d_power_q, 1'b0);
      if (i == 0)
        chk1(dsp_power_q, 1'b0);
      else
        chk1(dsp_power_q, 1'b1);
      abfs_host_i.restart(d);
      chk(d, (i == 0) ? 8'h20 : 8'h04);
      rdchk(PWR, 8'h00);
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      results;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    cyc(2);
    t_reset;
    t_boost;
    t_limit;
    t_oc;
    t_uv;
    t_ot;
    t_brownout;
    t_clock;
    results;
  end
endmodule // abfs_top_bench
